//--- logic/ohp_defs.vh
// Shared constants of the OLED host interface port
`ifndef OHP_DEFS_VH
`define OHP_DEFS_VH
// Strap encodings {iface_select_1, iface_select_0}
`define OHP_MODE_SERIAL 2'h0
`define OHP_MODE_I2C    2'h1
`define OHP_MODE_M6800  2'h2
`define OHP_MODE_I8080  2'h3
// Host data bus width and bit count of a serial byte
`define OHP_BUS_W       8
`define OHP_BIT_CNT_W   3
`define OHP_LAST_BIT    3'h7
// Serial lines carried on the data bus
`define OHP_SCLK_BIT    0
`define OHP_SERIAL_DATA_IN_BIT    1
// Buffer between the pins and the controller
`define OHP_FIFO_DEPTH  16
`define OHP_FIFO_AW     4
// Word layout in the buffer: {isData, byte}
`define OHP_WORD_W      9
`define OHP_WORD_DC     8
`endif

//--- logic/ohp_fifo.v
// Parameterised word buffer with valid/ready on both sides
`timescale 1ns/10ps
module ohp_fifo
#(
   parameter WIDTH = 9,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire             clk,
   input  wire             rstN,
   input  wire             flush,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   localparam [AW:0] FULL_CNT = DEPTH; // Fill level at which storage is full
   reg  [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
   reg  [AW-1:0]    wrPtr_r;           // Next slot to write
   reg  [AW-1:0]    rdPtr_r;           // Next slot to read
   reg  [AW:0]      count_r;           // Words held in storage
   reg  [WIDTH-1:0] outData_r;         // Registered head word
   reg              outValid_r;        // Head word present
   wire             push;
   wire             pop;

   // Full only when storage holds DEPTH words; output stage is extra
   assign inReady  = (count_r != FULL_CNT);
   assign push     = inValid && inReady;
   // Refill the output stage when it is empty or being taken
   assign pop      = (count_r != {(AW+1){1'b0}}) &&
                     (!outValid_r || outReady);
   assign outData  = outData_r;
   assign outValid = outValid_r;

   // Storage write; memory has no reset on purpose
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Pointers, fill level and output register
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrPtr_r    <= {AW{1'b0}};
         rdPtr_r    <= {AW{1'b0}};
         count_r    <= {(AW+1){1'b0}};
         outData_r  <= {WIDTH{1'b0}};
         outValid_r <= 1'b0;
      end
      else if (flush)
      begin
         // Drop everything held, including the head word
         wrPtr_r    <= {AW{1'b0}};
         rdPtr_r    <= {AW{1'b0}};
         count_r    <= {(AW+1){1'b0}};
         outValid_r <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rdPtr_r    <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
            outData_r  <= mem[rdPtr_r];
            outValid_r <= 1'b1;
         end
         else if (outReady)
         begin
            // Head taken with nothing behind it
            outValid_r <= 1'b0;
         end
         if (push && !pop)
         begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end
         else if (pop && !push)
         begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // ohp_fifo

//--- logic/ohp_host_port.v
// Host-facing parallel and serial port of the OLED controller
//
// Operation
// - Transfers accepted only while chip select asserted
// - Controller reset low initialises state to defaults
// - Parallel byte: select high data, low command
// - Serial byte: select high data, low command
// - 6800 access starts on enable high, select low
// - 8080 write starts on write strobe low
// - 8080 read starts on read strobe, drives bus
// - Eight-bit bidirectional bus, host writes, device reads
`timescale 1ns/10ps
`include "ohp_defs.vh"
module ohp_host_port
#(
   parameter DEPTH = `OHP_FIFO_DEPTH,
   parameter AW    = `OHP_FIFO_AW
)
(
   input  wire                  sys_clk,
   input  wire                  reset_n,
   input  wire                  ctrl_reset_n,
   input  wire                  iface_select_0,
   input  wire                  iface_select_1,
   input  wire                  chipSelN,
   input  wire                  dataCmdSel,
   input  wire                  rwSelWrN,
   input  wire                  enableRdN,
   input  wire [`OHP_BUS_W-1:0] host_data_bus_in,
   output wire [`OHP_BUS_W-1:0] host_data_bus_out,
   output wire [`OHP_BUS_W-1:0] host_data_bus_oe_n,
   output wire [`OHP_BUS_W-1:0] wordData,
   output wire                  wordIsData,
   output wire                  wordValid,
   input  wire                  wordReady,
   input  wire [`OHP_BUS_W-1:0] readData,
   output wire                  readTake,
   output wire                  ctrlInit,
   output wire                  portFull,
   output wire                  overrunSeen
);
   // Edge test on a synchronised level against its previous copy
   function rising;
      input now;
      input was;
      begin
         rising = now && !was;
      end
   endfunction

   reg                  rstMeta_r;      // Reset release, first stage
   reg                  rstSync_r;      // Reset release used below
   reg  [12:0]          pinMeta_r;      // Pin synchroniser, first stage
   reg  [12:0]          pinSync_r;      // Pin synchroniser, second stage
   reg  [3:0]           pinPrev_r;      // Previous strobes for edges
   reg  [`OHP_BUS_W-1:0] rdOut_r;       // Byte driven on reads
   reg                  rdDrive_r;      // Bus turned toward the host
   reg                  wrOpen_r;       // Parallel write in progress
   reg  [`OHP_BUS_W-1:0] shift_r;       // Serial shift register
   reg  [`OHP_BIT_CNT_W-1:0] bitCnt_r;  // Serial bits taken so far
   reg                  push_r;         // One word ready to store
   reg  [`OHP_WORD_W-1:0] pushWord_r;   // Word to store
   reg                  overrun_r;      // Sticky lost-word flag
   reg                  readTake_r;     // Read consumed a byte
   reg                  dcMeta_r;       // Data/command select, first stage
   reg                  dcSync_r;       // Data/command select, second stage
   reg                  enMeta_r;       // Enable or read strobe, first stage
   reg                  enSync_r;       // Enable or read strobe, second stage
   reg                  rdDrive_nxt;
   reg                  wrOpen_nxt;
   reg                  push_nxt;
   reg  [`OHP_WORD_W-1:0] pushWord_nxt;
   reg                  readTake_nxt;
   reg  [`OHP_BUS_W-1:0] shift_nxt;
   reg  [`OHP_BIT_CNT_W-1:0] bitCnt_nxt;
   wire                 fifoInReady;
   wire [`OHP_WORD_W-1:0] fifoOut;
   wire [1:0]           mode;
   wire                 csActive;
   wire                 dcLvl;
   wire                 rwLvl;
   wire                 enLvl;
   wire                 ctlRstN;
   wire [`OHP_BUS_W-1:0] busLvl;
   wire                 sclkRise;
   wire                 enRise;
   wire                 enFall;
   wire                 wrRise;
   wire                 wrFall;
   wire                 rdFall;

   // Reset: asynchronous assert, release through two flops
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end
      else
      begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // Every pin passes two flops; only the second stage is read
   always @(posedge sys_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         pinMeta_r <= 13'h1FFF;
         pinSync_r <= 13'h1FFF;
         // Enable copy rests low like its synchroniser: no false edge
         pinPrev_r <= 4'hE;
      end
      else
      begin
         pinMeta_r <= {ctrl_reset_n, iface_select_1, iface_select_0,
                       chipSelN, host_data_bus_in,
                       rwSelWrN};
         pinSync_r <= pinMeta_r;
         pinPrev_r <= {pinSync_r[0], pinSync_r[9],
                       pinSync_r[1 + `OHP_SCLK_BIT], enLvl};
      end
   end

   assign mode     = pinSync_r[11:10];
   assign csActive = !pinSync_r[9] && ctlRstN;
   assign busLvl   = pinSync_r[8:1];
   assign rwLvl    = pinSync_r[0];
   assign ctlRstN  = pinSync_r[12];
   assign dcLvl    = dcSync_r;
   assign enLvl    = enSync_r;

   // Data/command and enable lines get their own pair of flops
   always @(posedge sys_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         dcMeta_r <= 1'b0;
         dcSync_r <= 1'b0;
         enMeta_r <= 1'b0;
         enSync_r <= 1'b0;
      end
      else
      begin
         dcMeta_r <= dataCmdSel;
         dcSync_r <= dcMeta_r;
         enMeta_r <= enableRdN;
         enSync_r <= enMeta_r;
      end
   end

   // serial clock is bus line zero, data bus line one
   assign sclkRise = rising(busLvl[`OHP_SCLK_BIT], pinPrev_r[1]);
   assign enRise   = rising(enLvl, pinPrev_r[0]);
   assign enFall   = rising(pinPrev_r[0], enLvl);
   assign wrRise   = rising(rwLvl, pinPrev_r[3]);
   assign wrFall   = rising(pinPrev_r[3], rwLvl);
   assign rdFall   = enFall;

   // Transfer decode per mode
   always @*
   begin
      rdDrive_nxt  = rdDrive_r;
      wrOpen_nxt   = wrOpen_r;
      push_nxt     = 1'b0;
      pushWord_nxt = pushWord_r;
      readTake_nxt = 1'b0;
      shift_nxt    = shift_r;
      bitCnt_nxt   = bitCnt_r;
      if (!csActive)
      begin
         // Deselect ends any access and restarts serial framing
         rdDrive_nxt = 1'b0;
         wrOpen_nxt  = 1'b0;
         bitCnt_nxt  = {`OHP_BIT_CNT_W{1'b0}};
      end
      else
      begin
         case (mode)
            `OHP_MODE_M6800:
            begin
               if (enRise)
               begin
                  rdDrive_nxt  = rwLvl;
                  wrOpen_nxt   = !rwLvl;
                  readTake_nxt = rwLvl;
               end
               else if (enFall)
               begin
                  // Byte is latched as enable closes, after setup
                  // select level tags data or command
                  push_nxt     = wrOpen_r;
                  pushWord_nxt = {dcLvl, busLvl};
                  rdDrive_nxt  = 1'b0;
                  wrOpen_nxt   = 1'b0;
               end
            end
            `OHP_MODE_I8080:
            begin
               // write strobe low opens a write
               if (wrFall)
               begin
                  wrOpen_nxt = 1'b1;
               end
               else if (wrRise && wrOpen_r)
               begin
                  // select level tags data or command
                  push_nxt     = 1'b1;
                  pushWord_nxt = {dcLvl, busLvl};
                  wrOpen_nxt   = 1'b0;
               end
               // read strobe low turns the bus around
               if (rdFall)
               begin
                  rdDrive_nxt  = 1'b1;
                  readTake_nxt = 1'b1;
               end
               else if (enLvl)
               begin
                  rdDrive_nxt = 1'b0;
               end
            end
            `OHP_MODE_SERIAL:
            begin
               // shift MSB first on rising serial clock
               if (sclkRise)
               begin
                  shift_nxt  = {shift_r[`OHP_BUS_W-2:0],
                                busLvl[`OHP_SERIAL_DATA_IN_BIT]};
                  bitCnt_nxt = bitCnt_r + {{(`OHP_BIT_CNT_W-1){1'b0}},
                                           1'b1};
                  if (bitCnt_r == `OHP_LAST_BIT)
                  begin
                     // select sampled on the eighth bit
                     push_nxt     = 1'b1;
                     pushWord_nxt = {dcLvl, shift_r[`OHP_BUS_W-2:0],
                                     busLvl[`OHP_SERIAL_DATA_IN_BIT]};
                  end
               end
            end
            default:
            begin
               // two-wire mode needs board wiring; accepts nothing
               rdDrive_nxt = 1'b0;
               wrOpen_nxt  = 1'b0;
            end
         endcase
      end
   end

   // controller reset pin clears transfer state; pushWord_r and rdOut_r keep their values
   always @(posedge sys_clk or negedge rstSync_r)
   begin
      if (!rstSync_r)
      begin
         rdDrive_r  <= 1'b0;
         wrOpen_r   <= 1'b0;
         push_r     <= 1'b0;
         pushWord_r <= {`OHP_WORD_W{1'b0}};
         readTake_r <= 1'b0;
         shift_r    <= {`OHP_BUS_W{1'b0}};
         bitCnt_r   <= {`OHP_BIT_CNT_W{1'b0}};
         rdOut_r    <= {`OHP_BUS_W{1'b0}};
         overrun_r  <= 1'b0;
      end
      else if (!ctlRstN)
      begin
         rdDrive_r  <= 1'b0;
         wrOpen_r   <= 1'b0;
         push_r     <= 1'b0;
         readTake_r <= 1'b0;
         shift_r    <= {`OHP_BUS_W{1'b0}};
         bitCnt_r   <= {`OHP_BIT_CNT_W{1'b0}};
         overrun_r  <= 1'b0;
      end
      else
      begin
         rdDrive_r  <= rdDrive_nxt;
         wrOpen_r   <= wrOpen_nxt;
         push_r     <= push_nxt;
         pushWord_r <= pushWord_nxt;
         readTake_r <= readTake_nxt;
         shift_r    <= shift_nxt;
         bitCnt_r   <= bitCnt_nxt;
         // Read byte is frozen at the start of the access
         if (readTake_nxt)
         begin
            rdOut_r <= readData;
         end
         // Host has no wait line, so a word into a full buffer is lost
         if (push_r && !fifoInReady)
         begin
            overrun_r <= 1'b1;
         end
      end
   end

   // device drives all eight lines only during a read
   assign host_data_bus_out  = rdOut_r;
   assign host_data_bus_oe_n = {`OHP_BUS_W{!rdDrive_r}};
   assign readTake           = readTake_r;
   assign ctrlInit           = !ctlRstN;
   assign portFull           = !fifoInReady;
   assign overrunSeen        = overrun_r;
   assign wordData           = fifoOut[`OHP_BUS_W-1:0];
   assign wordIsData         = fifoOut[`OHP_WORD_DC];

   // Buffer toward the controller; flushed by the controller reset
   ohp_fifo
   #(
      .WIDTH (`OHP_WORD_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   )
   uFifo
   (
      .clk      (sys_clk),
      .rstN     (rstSync_r),
      .flush    (!ctlRstN),
      .inData   (pushWord_r),
      .inValid  (push_r),
      .inReady  (fifoInReady),
      .outData  (fifoOut),
      .outValid (wordValid),
      .outReady (wordReady)
   );
endmodule // ohp_host_port

//--- sim/ohp_port_sva.sv
// Concurrent checks on the host port pins and word output
`timescale 1ns/10ps
module ohp_port_sva
(
   input wire       sys_clk,
   input wire       reset_n,
   input wire       ctrl_reset_n,
   input wire       iface_select_0,
   input wire       iface_select_1,
   input wire       chipSelN,
   input wire       enableRdN,
   input wire [7:0] host_data_bus_out,
   input wire [7:0] host_data_bus_oe_n,
   input wire [7:0] wordData,
   input wire       wordIsData,
   input wire       wordValid,
   input wire       wordReady,
   input wire [7:0] readData,
   input wire       readTake,
   input wire       ctrlInit,
   input wire       overrunSeen
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Parallel strobe at rest: enable low for 6800, read high for 8080
   wire parIdle = iface_select_1 && (enableRdN == iface_select_0);

   oe_whole_a: assert property (
      host_data_bus_oe_n == 8'h00 || host_data_bus_oe_n == 8'hFF)
      else $error("Bus enables split");
   take_pulse_a: assert property (readTake |=> !readTake)
      else $error("Read start pulse too long");
   take_drive_a: assert property (
      readTake |-> host_data_bus_oe_n == 8'h00 &&
      host_data_bus_out == $past(readData))
      else $error("Read start without bus drive");
   cs_gate_a: assert property (chipSelN [*5] |-> !readTake)
      else $error("Read started while deselected");
   ctl_init_a: assert property (
      $stable(ctrl_reset_n) [*4] |-> ctrlInit == !ctrl_reset_n)
      else $error("Init level wrong");
   init_clear_a: assert property (
      ctrlInit [*3] |-> !wordValid && !overrunSeen &&
      host_data_bus_oe_n == 8'hFF)
      else $error("State not cleared in init");
   strap_quiet_a: assert property (
      !iface_select_1 |-> host_data_bus_oe_n == 8'hFF && !readTake)
      else $error("Bus driven in serial mode");
   oe_release_a: assert property (
      parIdle [*4] |-> host_data_bus_oe_n == 8'hFF)
      else $error("Bus held after strobe end");
   word_hold_a: assert property (
      ctrl_reset_n [*4] ##0 (wordValid && !wordReady) |=>
      wordValid && $stable({wordIsData, wordData}))
      else $error("Word changed while stalled");

   // Main scenarios reached
   cover property (readTake && !iface_select_0);
   cover property (readTake && iface_select_0);
   cover property (wordValid && wordReady && !iface_select_1);
   cover property ($rose(overrunSeen));
endmodule // ohp_port_sva

//--- sim/ohp_host_model.sv
// Host microcontroller model driving the port pins
`timescale 1ns/10ps
module ohp_host_model
(
   input  wire       sys_clk,
   input  wire [7:0] devOut,
   input  wire [7:0] devOeN,
   output reg        chipSelN,
   output reg        dataCmdSel,
   output reg        rwSelWrN,
   output reg        enableRdN,
   output wire [7:0] busLevel
);
   reg       hostDrive; // Host owns the bus
   reg [7:0] hostByte;  // Byte the host puts out

   // shared bus
   // No pull on the bus, so a released bus shows the inverse
   assign busLevel = !devOeN[0] ? devOut :
                     hostDrive ? hostByte : ~hostByte;

   initial
   begin
      chipSelN = 1;
      dataCmdSel = 0;
      rwSelWrN = 1;
      enableRdN = 0;
      hostDrive = 0;
      hostByte = 8'h00;
   end

   // Wait n edges, then step just past the edge
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // one parallel access, select wrapped around the strobe
   task par_acc(input bit m80, input bit rd, input bit sel,
                input bit dc, input logic [7:0] b);
      tick(1);
      enableRdN = m80;
      rwSelWrN = m80 | rd;
      chipSelN = !sel;
      dataCmdSel = dc;
      hostByte = b;
      hostDrive = !rd;
      tick(4);
      if (!m80)
         enableRdN = 1;
      else if (rd)
         enableRdN = 0;
      else
         rwSelWrN = 0;
      tick(8);
      enableRdN = m80;
      rwSelWrN = m80 | rd;
      tick(4);
      chipSelN = 1;
      hostDrive = 0;
      tick(4);
   endtask

   // serial frame, MSB first; clock rests low outside frames
   task ser_bits(input bit dc, input logic [7:0] b, input int n);
      hostDrive = 1;
      hostByte = 8'h00;
      tick(2);
      chipSelN = 0;
      dataCmdSel = dc;
      tick(20);
      for (int i = 0; i < n; i++)
      begin
         // lines two and one tied on the board
         hostByte[2:1] = {2{b[7-i]}};
         tick(20);
         hostByte[0] = 1;
         tick(20);
         hostByte[0] = 0;
      end
      chipSelN = 1;
      tick(20);
   endtask
endmodule // ohp_host_model

//--- sim/testbench.sv
// Self-checking bench for the host port with a host model
`timescale 1ns/10ps
module testbench;
   logic       sys_clk, reset_n, ctrl_reset_n, wordReady, stall;
   logic       iface_select_0, iface_select_1;
   logic [7:0] readData;
   wire        chipSelN, dataCmdSel, rwSelWrN, enableRdN;
   wire        wordIsData, wordValid, readTake, ctrlInit;
   wire        portFull, overrunSeen;
   wire  [7:0] busLevel, busOut, busOeN, wordData;
   logic [8:0] wq[$];  // Expected words {isData, byte}
   logic [7:0] rq[$];  // Expected read bytes
   int         errorCnt, cmpCount, k, n;
   logic [7:0] b;

   ohp_host_port ohp_host_port_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .ctrl_reset_n(ctrl_reset_n),
      .iface_select_0(iface_select_0), .iface_select_1(iface_select_1),
      .chipSelN(chipSelN), .dataCmdSel(dataCmdSel),
      .rwSelWrN(rwSelWrN), .enableRdN(enableRdN),
      .host_data_bus_in(busLevel), .host_data_bus_out(busOut),
      .host_data_bus_oe_n(busOeN), .wordData(wordData),
      .wordIsData(wordIsData), .wordValid(wordValid),
      .wordReady(wordReady), .readData(readData),
      .readTake(readTake), .ctrlInit(ctrlInit),
      .portFull(portFull), .overrunSeen(overrunSeen));

   ohp_host_model ohp_host_model_inst (.sys_clk(sys_clk),
      .devOut(busOut), .devOeN(busOeN), .chipSelN(chipSelN),
      .dataCmdSel(dataCmdSel), .rwSelWrN(rwSelWrN),
      .enableRdN(enableRdN), .busLevel(busLevel));

   // Free-running system clock
   initial
   begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Sink stalls at random; held off entirely while filling
   always @(posedge sys_clk)
   begin
      #1;
      wordReady = !stall && ($urandom % 4 != 0);
   end

   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task chk(input logic [8:0] got, input logic [8:0] exp);
      cmpCount++;
      if (got !== exp)
         begin
         errorCnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
   endtask

   task final_report;
      $display("Counts: compares=%0d errors=%0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Parallel write of a random byte; noted only when it must arrive
   task wr(input bit m, input bit sel, input bit keep, input bit dc);
      logic [7:0] v;
      v = $urandom;
      if (keep)
         wq.push_back({dc, v});
      ohp_host_model_inst.par_acc(m, 1'b0, sel, dc, v);
   endtask

   // Bounded wait for every noted result to show up
   task drain;
      int i;
      for (i = 0; i < 3000 && wq.size() + rq.size() > 0; i++)
         tick(1);
      if (wq.size() + rq.size() > 0)
         begin
         errorCnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, wq.size(), 0);
         final_report;
         end
   endtask

   // Watcher: oldest note against each word or read that appears
   always @(posedge sys_clk)
      if (reset_n === 1'b1)
      begin
         if (wordValid === 1'b1 && wordReady === 1'b1)
            chk({wordIsData, wordData}, wq.size() ? wq.pop_front() :
                ~{wordIsData, wordData});
         if (readTake === 1'b1)
            chk({1'b0, busOut}, {1'b0, rq.size() ? rq.pop_front() :
                ~busOut});
      end

   initial
   begin
      reset_n = 0;
      ctrl_reset_n = 1;
      {iface_select_1, iface_select_0} = 2'h2;
      stall = 0;
      wordReady = 0;
      readData = 8'h00;
      errorCnt = 0;
      cmpCount = 0;
      b = $urandom(32'h9C2925B3);
      repeat (6) @(posedge sys_clk);
      #1;
      reset_n = 1;
      tick(6);
      // Both parallel styles: writes, a read, a deselected access
      for (k = 0; k < 2; k++)
      begin
         {iface_select_1, iface_select_0} = {1'b1, k[0]};
         for (n = 0; n < 4; n++)
            wr(k[0], 1'b1, 1'b1, n[0]);
         readData = $urandom;
         rq.push_back(readData);
         ohp_host_model_inst.par_acc(k[0], 1'b1, 1'b1, 1'b0, 0);
         wr(k[0], 1'b0, 1'b0, 1'b1);
         drain;
         $display("Test parallel style %0d done", k);
      end
      // Serial frames, third one cut short by deselect
      {iface_select_1, iface_select_0} = 2'h0;
      for (k = 0; k < 4; k++)
      begin
         b = $urandom;
         n = (k == 2) ? 3 : 8;
         if (n == 8)
            wq.push_back({k[0], b});
         ohp_host_model_inst.ser_bits(k[0], b, n);
      end
      drain;
      // Two-wire strap accepts nothing
      {iface_select_1, iface_select_0} = 2'h1;
      ohp_host_model_inst.ser_bits(1'b1, 8'hA5, 8);
      tick(10);
      $display("Test serial and strap done");
      // Fill past capacity, then controller init flushes it
      {iface_select_1, iface_select_0} = 2'h3;
      stall = 1;
      tick(2);
      for (k = 0; k < 18; k++)
         wr(1'b1, 1'b1, 1'b0, k[0]);
      chk({8'h00, portFull}, 9'h001);
      chk({8'h00, overrunSeen}, 9'h001);
      ctrl_reset_n = 0;
      tick(6);
      chk({8'h00, ctrlInit}, 9'h001);
      chk({wordValid, 7'h00, overrunSeen}, 9'h000);
      ctrl_reset_n = 1;
      stall = 0;
      tick(6);
      wr(1'b1, 1'b1, 1'b1, 1'b1);
      drain;
      $display("Test overflow and init done");
      final_report;
   end
endmodule // testbench

bind ohp_host_port ohp_port_sva ohp_port_sva_inst (.sys_clk(sys_clk),
   .reset_n(reset_n), .ctrl_reset_n(ctrl_reset_n),
   .iface_select_0(iface_select_0), .iface_select_1(iface_select_1),
   .chipSelN(chipSelN), .enableRdN(enableRdN),
   .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe_n(host_data_bus_oe_n), .wordData(wordData),
   .wordIsData(wordIsData), .wordValid(wordValid),
   .wordReady(wordReady), .readData(readData), .readTake(readTake),
   .ctrlInit(ctrlInit), .overrunSeen(overrunSeen));
